// ==== core/pot_terminal_wiper_control.sv ====
// Overview of operation
// - Digital supply low: ignore all commands, terminals forced to brown-out state.
// - Digital supply rising: wiper and terminal-connect registers load defaults.
// - Wiper default is mid-scale code.
// - Analog good, digital bad: wiper at mid-scale; both good: follows register.
// - Commands accepted only when digital supply is at full operating level.
// - Hardware shutdown opens terminal A and connects wiper to terminal B.
// - Hardware shutdown overrides connect bits without altering them.
// - Hardware shutdown leaves wiper register untouched; wiper returns afterwards.
// - Serial interface stays active during hardware shutdown.
// - Connect settings never change wiper or restrict access.
// - Connect register has A, wiper, B connect bits and software shutdown bit.
// - Software shutdown masks but retains the per-terminal connect bits.
// - Latch gate high blocks wiper transfer; low allows it continuously.
// - Blocked transfers still allow register updates; gate affects nothing else.
// - Wiper never receives a partially loaded value.
// - After power-on or brown-out the connect register reads all ones.
// - Bit 3 software shutdown, bit 2 A, bit 1 wiper, bit 0 B.
// - Upper four connect register bits are reserved, read one, not writable.
`timescale 1ns/1ps
`include "pot_map.svh"
module pot_terminal_wiper_control
	import pot_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Supply indications, asynchronous
	input  wire logic         digital_supply_good,
	input  wire logic         digital_supply_full,
	input  wire logic         analog_supply_good,
	// Control pins, asynchronous
	input  wire logic         hw_shutdown_n,
	input  wire logic         wiper_update_gate_n,
	// Command port
	input  bus_req_t          bus_req,
	output logic       [7:0]  reg_rdata,
	output logic              cmd_error,
	// Analog network controls
	output logic       [7:0]  wiper_code,
	output term_state_t       terminals
);

	function automatic logic is_wiper(input logic [3:0] addr);
		is_wiper = (addr == `WIPER_ADDR);
	endfunction

	function automatic logic is_terminal_connect_reg(input logic [3:0] addr);
		is_terminal_connect_reg = (addr == `TERMINAL_CONNECT_REG_ADDR);
	endfunction

	// Reset: asserted at once by either source, released in step with the clock
	logic       dig_rst_n;
	logic [1:0] rst_sync;
	logic       core_rst_n;

	assign dig_rst_n = rst_n & digital_supply_good;

	always_ff @(posedge core_clk or negedge dig_rst_n) begin
		if (!dig_rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign core_rst_n = rst_sync[1];

	// Pin synchronisers
	logic [3:0] pins_s;
	logic       hw_sd_n_s;
	logic       gate_n_s;
	logic       analog_good_s;
	logic       digital_full_s;

	pin_sync #(
		.WIDTH     (4),
		.RESET_VAL (`PIN_SYNC_RESET)
	) u_pin_sync (
		.core_clk (core_clk),
		.rst_n    (core_rst_n),
		.async_in ({digital_supply_full, analog_supply_good,
		            wiper_update_gate_n, hw_shutdown_n}),
		.sync_out (pins_s)
	);

	assign hw_sd_n_s      = pins_s[0];
	assign gate_n_s       = pins_s[1];
	assign analog_good_s  = pins_s[2];
	assign digital_full_s = pins_s[3];

	// Power state: acceptance of commands
	power_state_t pwr;
	power_state_t next_pwr;
	logic         accept;

	always_comb begin
		case (pwr)
			PWR_DOWN:     next_pwr = digital_full_s ? PWR_FULL : PWR_MARGINAL;
			PWR_MARGINAL: next_pwr = digital_full_s ? PWR_FULL : PWR_MARGINAL;
			PWR_FULL:     next_pwr = digital_full_s ? PWR_FULL : PWR_MARGINAL;
			default:      next_pwr = PWR_DOWN;
		endcase
	end

	always_ff @(posedge core_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pwr <= PWR_DOWN;
		end else begin
			pwr <= next_pwr;
		end
	end

	// Below full level the command port is simply deaf; acceptance there is not promised
	assign accept = (pwr == PWR_FULL);

	// Registers; shutdown sources never enter these equations
	logic [7:0] wiper_reg;
	logic [7:0] next_wiper_reg;
	terminal_connect_reg_t      terminal_connect_reg;
	terminal_connect_reg_t      next_terminal_connect_reg;
	logic [7:0] next_rdata;
	logic       next_cmd_error;
	logic       wr_ok;
	logic       rd_ok;

	always_comb begin
		next_wiper_reg = wiper_reg;
		next_terminal_connect_reg      = terminal_connect_reg;
		next_rdata     = 8'h00;
		next_cmd_error = 1'b0;
		wr_ok          = accept & bus_req.wr;
		rd_ok          = accept & bus_req.rd;
		if (wr_ok) begin
			if (is_wiper(bus_req.addr)) begin
				next_wiper_reg = bus_req.wdata;
			end else if (is_terminal_connect_reg(bus_req.addr)) begin
				next_terminal_connect_reg.soft_shutdown_n = bus_req.wdata[`TERMINAL_CONNECT_REG_SOFT_BIT];
				next_terminal_connect_reg.term_a_connect  = bus_req.wdata[`TERMINAL_CONNECT_REG_A_BIT];
				next_terminal_connect_reg.wiper_connect   = bus_req.wdata[`TERMINAL_CONNECT_REG_W_BIT];
				next_terminal_connect_reg.term_b_connect  = bus_req.wdata[`TERMINAL_CONNECT_REG_B_BIT];
			end else begin
				next_cmd_error = 1'b1;
			end
		end
		if (accept && (bus_req.inc || bus_req.dec)) begin
			// Steps exist only for the wiper and saturate at the ends
			if (!is_wiper(bus_req.addr)) begin
				next_cmd_error = 1'b1;
			end else if (bus_req.inc && wiper_reg != `WIPER_MAX) begin
				next_wiper_reg = wiper_reg + 8'h01;
			end else if (bus_req.dec && wiper_reg != `WIPER_MIN) begin
				next_wiper_reg = wiper_reg - 8'h01;
			end
		end
		if (rd_ok) begin
			if (is_wiper(bus_req.addr)) begin
				next_rdata = wiper_reg;
			end else if (is_terminal_connect_reg(bus_req.addr)) begin
				next_rdata = terminal_connect_reg;
			end else begin
				next_cmd_error = 1'b1;
			end
		end
		next_terminal_connect_reg.reserved = `TERMINAL_CONNECT_REG_RSVD;
	end

	always_ff @(posedge core_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			wiper_reg <= `WIPER_MID;
			terminal_connect_reg      <= terminal_connect_reg_t'(`TERMINAL_CONNECT_REG_RESET);
			reg_rdata <= 8'h00;
			cmd_error <= 1'b0;
		end else begin
			wiper_reg <= next_wiper_reg;
			terminal_connect_reg      <= next_terminal_connect_reg;
			reg_rdata <= next_rdata;
			cmd_error <= next_cmd_error;
		end
	end

	// Wiper output: takes only committed register values, so a write in flight never leaks
	logic [7:0] next_wiper_code;

	always_comb begin
		next_wiper_code = wiper_code;
		if (!analog_good_s) begin
			next_wiper_code = `WIPER_MID;
		end else if (!gate_n_s) begin
			next_wiper_code = wiper_reg;
		end
	end

	// Reset holds mid-scale whenever digital supply is bad
	always_ff @(posedge core_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			wiper_code <= `WIPER_MID;
		end else begin
			wiper_code <= next_wiper_code;
		end
	end

	// Terminal connections
	term_state_t next_terminals;

	terminal_resolve u_terminal_resolve (
		.hw_shutdown_n (hw_sd_n_s),
		.terminal_connect_reg          (terminal_connect_reg),
		.terminals     (next_terminals)
	);

	always_ff @(posedge core_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			terminals <= term_state_t'(`TERM_BROWNOUT);
		end else begin
			terminals <= next_terminals;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!core_rst_n);

	sequence s_wiper_write;
		accept && bus_req.wr && is_wiper(bus_req.addr) && !bus_req.inc && !bus_req.dec;
	endsequence

	sequence s_gate_open;
		!gate_n_s && analog_good_s;
	endsequence

	a_reset_defaults: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(core_rst_n) |-> wiper_reg == `WIPER_MID && terminal_connect_reg == terminal_connect_reg_t'(`TERMINAL_CONNECT_REG_RESET)
		&& wiper_code == `WIPER_MID)
		else $error("registers not at defaults after reset release");

	a_write_reaches_wiper: assert property (
		s_wiper_write ##1 s_gate_open[*2] |-> wiper_code == $past(bus_req.wdata, 2))
		else $error("written wiper value not transferred while gate open");

	a_gate_blocks: assert property (
		gate_n_s && analog_good_s |=> $stable(wiper_code))
		else $error("wiper moved while gate closed");

	a_blocked_write_lands: assert property (
		s_wiper_write and (gate_n_s && hw_sd_n_s) |=> wiper_reg == $past(bus_req.wdata))
		else $error("register write lost while gate closed");

	a_hw_shutdown_state: assert property (
		!hw_sd_n_s ##1 !hw_sd_n_s |-> terminals == term_state_t'(`TERM_SHUTDOWN))
		else $error("hardware shutdown pattern not applied");

	a_shutdown_keeps_bits: assert property (
		!hw_sd_n_s && !(accept && (bus_req.wr || bus_req.inc || bus_req.dec))
		|=> $stable(terminal_connect_reg) && $stable(wiper_reg))
		else $error("shutdown altered stored registers");

	a_soft_shutdown: assert property (
		!terminal_connect_reg.soft_shutdown_n |=> terminals == term_state_t'(`TERM_SHUTDOWN))
		else $error("software shutdown pattern not applied");

	a_bits_govern: assert property (
		hw_sd_n_s && terminal_connect_reg.soft_shutdown_n |=> terminals == {$past(terminal_connect_reg[2:0]), 1'b0})
		else $error("connect bits not governing terminals");

	a_reserved_ones: assert property (
		rd_ok && is_terminal_connect_reg(bus_req.addr) |=> reg_rdata[7:4] == `TERMINAL_CONNECT_REG_RSVD)
		else $error("reserved bits not read as one");

	a_marginal_deaf: assert property (
		!accept |=> $stable(wiper_reg) && $stable(terminal_connect_reg))
		else $error("command taken below full supply");

	a_read_one_cycle: assert property (
		!rd_ok |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");

	a_brownout_state: assert property (@(posedge core_clk) disable iff (!rst_n)
		!digital_supply_good |-> terminals == term_state_t'(`TERM_BROWNOUT)
		&& wiper_code == `WIPER_MID)
		else $error("brown-out state not forced");

	a_analog_mid: assert property (
		!analog_good_s |=> wiper_code == `WIPER_MID)
		else $error("wiper not at mid-scale without analog supply");

	a_wiper_follows: assert property (
		s_gate_open |=> wiper_code == $past(wiper_reg))
		else $error("wiper output not following register");

	a_shutdown_serial: assert property (
		!hw_sd_n_s ##0 s_wiper_write |=> wiper_reg == $past(bus_req.wdata))
		else $error("write lost during hardware shutdown");

	a_terminal_connect_reg_write: assert property (
		accept && bus_req.wr && is_terminal_connect_reg(bus_req.addr) |=> terminal_connect_reg[3:0] == $past(bus_req.wdata[3:0]))
		else $error("connect bits not written");

	a_rdata_wiper: assert property (
		rd_ok && is_wiper(bus_req.addr) |=> reg_rdata == $past(wiper_reg))
		else $error("wiper read data wrong");

endmodule

// ==== core/pot_map.svh ====
`ifndef POT_MAP_SVH
`define POT_MAP_SVH

// Register addresses on the command port
`define WIPER_ADDR      4'h0
`define TERMINAL_CONNECT_REG_ADDR       4'h4

// Wiper codes, 8-bit resolution
`define WIPER_MID       8'h7F
`define WIPER_MAX       8'hFF
`define WIPER_MIN       8'h00

// Terminal-connect register
`define TERMINAL_CONNECT_REG_RESET      8'hFF
`define TERMINAL_CONNECT_REG_RSVD       4'hF
`define TERMINAL_CONNECT_REG_SOFT_BIT   3
`define TERMINAL_CONNECT_REG_A_BIT      2
`define TERMINAL_CONNECT_REG_W_BIT      1
`define TERMINAL_CONNECT_REG_B_BIT      0

// Terminal states as {a_connect, w_connect, b_connect, wb_short}
`define TERM_SHUTDOWN   4'h7
`define TERM_BROWNOUT   4'hE

// Synchroniser reset values {digital_full, analog_good, gate_n, shutdown_n}
`define PIN_SYNC_RESET  4'h3

`endif

// ==== core/pot_pkg.sv ====
package pot_pkg;

	typedef struct packed {
		logic [3:0] reserved;
		logic       soft_shutdown_n;
		logic       term_a_connect;
		logic       wiper_connect;
		logic       term_b_connect;
	} terminal_connect_reg_t;

	typedef struct packed {
		logic a_connect;
		logic w_connect;
		logic b_connect;
		logic wb_short;
	} term_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       inc;
		logic       dec;
	} bus_req_t;

	typedef enum logic [1:0] {
		PWR_DOWN     = 2'b00,
		PWR_MARGINAL = 2'b01,
		PWR_FULL     = 2'b10
	} power_state_t;

endpackage

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
	parameter int         WIDTH     = 4,
	parameter logic [3:0] RESET_VAL = 4'h0
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// Asynchronous pins and their synchronised copies
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// Only the second stage is read outside this module
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1   <= RESET_VAL[WIDTH-1:0];
			sync_out <= RESET_VAL[WIDTH-1:0];
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ==== core/terminal_resolve.sv ====
`timescale 1ns/1ps
`include "pot_map.svh"
module terminal_resolve
	import pot_pkg::*;
(
	// Shutdown sources and stored connect bits
	input  wire logic        hw_shutdown_n,
	input  terminal_connect_reg_t            terminal_connect_reg,
	// Resolved terminal connections
	output term_state_t      terminals
);

	// Either shutdown source wins; the stored bits are only masked, never changed
	always_comb begin
		if (!hw_shutdown_n || !terminal_connect_reg.soft_shutdown_n) begin
			terminals = term_state_t'(`TERM_SHUTDOWN);
		end else begin
			terminals.a_connect = terminal_connect_reg.term_a_connect;
			terminals.w_connect = terminal_connect_reg.wiper_connect;
			terminals.b_connect = terminal_connect_reg.term_b_connect;
			terminals.wb_short  = 1'b0;
		end
	end

endmodule

// ==== dv/cmd_host.sv ====
`timescale 1ns/1ps
module cmd_host
	import pot_pkg::*;
(
	// Clock
	input  wire logic core_clk,
	// Command port and latch gate
	output bus_req_t  bus_req,
	output logic      gate_n
);
	initial begin
		bus_req = '0;
		gate_n  = 1'b0; // Left low when updates need no sync
	end

	// An idle edge passes between requests, so a release is never overwritten in one step
	task automatic send(input logic [3:0] kind, input logic [3:0] addr, input logic [7:0] data);
		bus_req_t r;
		r = '0;
		r.addr = addr;
		r.wdata = data;
		{r.wr, r.rd, r.inc, r.dec} = kind;
		@(posedge core_clk);
		bus_req <= r;
		@(posedge core_clk);
		bus_req <= '0;
	endtask

	// Called on a rising edge; high freezes the wiper output
	task automatic set_gate(input logic level_n);
		gate_n <= level_n;
	endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
	import pot_pkg::*;
	logic        core_clk;
	logic        rst_n;
	logic        dsg;
	logic        dsf;
	logic        asg;
	logic        hw_shutdown_n_n;
	bus_req_t    bus_req;
	logic        gate_n;
	logic [7:0]  reg_rdata;
	logic        cmd_error;
	logic [7:0]  wiper_code;
	term_state_t terminals;
	int          errors;
	int          comparisons;
	int          seed;
	int          m_wiper;
	int          m_terminal_connect_reg;
	int          m_code;
	logic [31:0] v;

	cmd_host host (.core_clk(core_clk), .bus_req(bus_req), .gate_n(gate_n));

	pot_terminal_wiper_control uut (
		.core_clk(core_clk), .rst_n(rst_n), .digital_supply_good(dsg),
		.digital_supply_full(dsf), .analog_supply_good(asg), .hw_shutdown_n(hw_shutdown_n_n),
		.wiper_update_gate_n(gate_n), .bus_req(bus_req), .reg_rdata(reg_rdata),
		.cmd_error(cmd_error), .wiper_code(wiper_code), .terminals(terminals)
	);

	always #20 core_clk = ~core_clk;

	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [3:0] exp_term();
		if (!dsg)
			return 4'hE;
		if (!hw_shutdown_n_n || !m_terminal_connect_reg[3])
			return 4'h7;
		return {m_terminal_connect_reg[2:0], 1'b0};
	endfunction

	// Pins pass two sync flops plus an output register, so allow four edges;
	// ends on an edge so that the next pin change lands on one
	task automatic check_all();
		repeat (4) @(posedge core_clk);
		#1;
		if (!gate_n)
			m_code = m_wiper;
		chk("terminals", {4'h0, exp_term()}, {4'h0, terminals});
		chk("wiper_code", asg ? m_code[7:0] : 8'h7F, wiper_code);
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host.send(4'h8, a, d);
		if (dsf && dsg && a == 4'h0)
			m_wiper = d;
		if (dsf && dsg && a == 4'h4)
			m_terminal_connect_reg = d[3:0];
	endtask

	task automatic rd(input logic [3:0] a, input string what, input logic [7:0] exp);
		host.send(4'h4, a, 8'h00);
		#1;
		chk(what, exp, reg_rdata);
		chk("read cmd_error", {7'h0, dsf && a != 4'h0 && a != 4'h4}, {7'h0, cmd_error});
		@(posedge core_clk);
	endtask

	task automatic step(input logic up, input logic [3:0] a);
		host.send(up ? 4'h2 : 4'h1, a, 8'h00);
		#1;
		if (a == 4'h0 && up && m_wiper < 255)
			m_wiper++;
		if (a == 4'h0 && !up && m_wiper > 0)
			m_wiper--;
		chk("cmd_error", {7'h0, a != 4'h0}, {7'h0, cmd_error});
		@(posedge core_clk);
	endtask

	initial begin
		#200000;
		errors++;
		give_verdict();
	end

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		{dsg, dsf, asg, hw_shutdown_n_n} = 4'hF;
		seed = 29;
		m_wiper = 8'h7F;
		m_terminal_connect_reg = 4'hF;
		m_code = 8'h7F;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		check_all();
		rd(4'h0, "wiper", 8'h7F);
		rd(4'h4, "terminal_connect_reg", 8'hFF);
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			v = $random(seed);
			wr(v[8] ? 4'h4 : 4'h0, v[7:0]);
			check_all();
			rd(4'h4, "terminal_connect_reg", {4'hF, m_terminal_connect_reg[3:0]});
			rd(4'h0, "wiper", m_wiper[7:0]);
		end
		$display("test random done");
		wr(4'h0, 8'hFE);
		step(1'b1, 4'h0);
		step(1'b1, 4'h0);
		rd(4'h0, "wiper", m_wiper[7:0]);
		wr(4'h0, 8'h01);
		step(1'b0, 4'h0);
		step(1'b0, 4'h0);
		step(1'b1, 4'h4);
		rd(4'h0, "wiper", m_wiper[7:0]);
		rd(4'h2, "reserved", 8'h00);
		$display("test step done");
		wr(4'h4, 8'h0D);
		hw_shutdown_n_n <= 1'b0;
		wr(4'h4, 8'h0A);
		wr(4'h0, 8'h20);
		step(1'b1, 4'h0);
		check_all();
		rd(4'h4, "terminal_connect_reg", 8'hFA);
		rd(4'h0, "wiper", m_wiper[7:0]);
		hw_shutdown_n_n <= 1'b1;
		check_all();
		$display("test shutdown done");
		host.set_gate(1'b1);
		check_all();
		wr(4'h0, 8'h33);
		check_all();
		rd(4'h0, "wiper", 8'h33);
		host.set_gate(1'b0);
		check_all();
		asg <= 1'b0;
		check_all();
		asg <= 1'b1;
		check_all();
		$display("test latch done");
		dsf <= 1'b0;
		repeat (4) @(posedge core_clk);
		wr(4'h0, 8'h11);
		rd(4'h0, "ignored", 8'h00);
		dsf <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(4'h0, "wiper", m_wiper[7:0]);
		wr(4'h4, 8'h02);
		dsg <= 1'b0;
		m_wiper = 8'h7F;
		m_terminal_connect_reg = 4'hF;
		check_all();
		wr(4'h0, 8'h44);
		dsg <= 1'b1;
		check_all();
		repeat (2) @(posedge core_clk);
		rd(4'h0, "wiper", 8'h7F);
		rd(4'h4, "terminal_connect_reg", 8'hFF);
		$display("test supply done");
		give_verdict();
	end
endmodule
